// ===== hw/gci_ci_monitor_map.svh
// Purpose: Offsets, field positions, reset values for the C/I and monitor
//          register bank.
// Assumes: Register indices are word indices; byte address is index * 4.
// Notes on behaviour
// - Bus access request bit makes the controller try to drive C/I0.
// - C/I0 transmit field writable anytime, sent every frame while bus access request and TIC access enable are both set.
// - C/I1 transmit field writable anytime, sent every frame until rewritten.
// - C/I0 receive field loads only data stable for two frames.
// - C/I1 receive field loads only data stable for two frames.
// - C/I0 change interrupt when contents differ from value last read.
// - C/I1 change interrupt when contents differ from value last read.
// - Peek registers copy receive registers without any side effect.
// - Unused channel slots leave the data line released (all ones).
// - Received monitor byte loads receive field and raises data-available.
// - Reading monitor receive register frees it for the next byte.
// - Monitor receive field cleared when monitor channel is disabled.
// - Monitor channel select picks channel 0 or 1 for monitor fields.
// - TIC access enable gates every bus access attempt.
// - Each status source interrupts only while its mask bit is set.
`ifndef GCI_CI_MONITOR_MAP_SVH
`define GCI_CI_MONITOR_MAP_SVH

`define IDX_STATUS 10'h2a0
`define IDX_CONFIG 10'h2a2
`define IDX_MASK 10'h2a4
`define IDX_TIC 10'h2a6
`define IDX_CI0_TX 10'h2ae
`define IDX_CI0_RX 10'h2b0
`define IDX_CI0_PEEK 10'h2b2
`define IDX_CI1_TX 10'h2b4
`define IDX_CI1_RX 10'h2b6
`define IDX_CI1_PEEK 10'h2b8
`define IDX_MON_TX 10'h2ba
`define IDX_MON_RX 10'h2bc
`define IDX_MON_PEEK 10'h2be

`define BIT_BAR 7
`define BIT_TIC_EN 7
`define BIT_MON_SEL 0
`define BIT_MON_EN 1
`define BIT_CHG_CI1 7
`define BIT_CHG_CI0 6
`define BIT_MXBA 1
`define BIT_MRDA 0

`define RST_CI0 4'h0f
`define RST_CI1 6'h3f
`define RST_MON_TX 8'hff
`define RST_MON_RX 8'h00

`define FRAME_LAST 5'h1f
`define POS_MON0 24
`define POS_MON1 16
`define POS_CI0 12
`define POS_CI1 6

`endif

// ===== hw/gci_ci_monitor_pkg.sv
// Purpose: Types shared by the C/I and monitor register bank.
// Assumes: Nothing beyond the map header.
// Notes: Monitor transmit states are Gray coded along idle-loaded-sending.
package gci_ci_monitor_pkg;

    typedef enum logic [1:0] {
        MTX_IDLE = 2'b00,
        MTX_LOADED = 2'b01,
        MTX_SENDING = 2'b11
    } mtx_state_t;

    typedef struct packed {
        logic tic_en;
        logic mon_en;
        logic mon_sel;
    } gci_cfg_t;

    typedef struct packed {
        logic chg_ci1;
        logic chg_ci0;
        logic mxba;
        logic mrda;
    } gci_evt_t;

endpackage : gci_ci_monitor_pkg

// ===== hw/gci_ci_monitor_regs.sv
// Purpose: APB register bank and frame engine for the C/I0, C/I1 and
//          monitor channels of a GCI link.
// Assumes: 32-bit frame per frame sync; link clock and pins are sampled
//          through two flip-flops; APB answers in the second access cycle.
// Notes: Event bits are sticky, cleared by writing one; set beats clear.
`include "gci_ci_monitor_map.svh"

module gci_ci_monitor_regs
    import gci_ci_monitor_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic CLK_SYS,
    input wire logic RESETN,
    input wire logic CE,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [ADDR_W-1:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    output logic IRQ,
    input wire logic LINK_CLK_IN,
    input wire logic FRAME_SYNC_IN,
    input wire logic DOWNSTREAM_DATA_LINE_IN,
    output logic UPSTREAM_DATA_LINE_OUT,
    output logic UPSTREAM_DATA_LINE_OE
);

    // Decode needs index bits 11:2
    if (ADDR_W < 12) begin : g_addr_check
        $error("ADDR_W must be at least 12");
    end

    // Synchronisers: stage 1 feeds only stage 2
    logic [2:0] s1;
    logic [2:0] s2;
    logic dcl_d;

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            s1 <= 3'h0;
            s2 <= 3'h0;
            dcl_d <= 1'b0;
        end else if (CE) begin
            s1 <= {LINK_CLK_IN, FRAME_SYNC_IN, DOWNSTREAM_DATA_LINE_IN};
            s2 <= s1;
            dcl_d <= s2[2];
        end
    end

    logic dcl_rise;
    logic dcl_fall;
    logic fsc;
    logic dd;
    assign dcl_rise = s2[2] & ~dcl_d;
    assign dcl_fall = ~s2[2] & dcl_d;
    assign fsc = s2[1];
    assign dd = s2[0];

    function automatic logic at(input logic [ADDR_W-1:0] a,
                                input logic [9:0] idx);
        at = (a[11:2] == idx) && (a[1:0] == 2'b00);
    endfunction : at

    // State
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic irq;
    gci_cfg_t cfg;
    gci_evt_t status;
    gci_evt_t mask;
    logic bar;
    logic [3:0] ci0_tx;
    logic [5:0] ci1_tx;
    logic [7:0] mon_tx;
    logic [3:0] ci0_rx;
    logic [5:0] ci1_rx;
    logic [7:0] mon_rx;
    logic [3:0] ci0_prev;
    logic [5:0] ci1_prev;
    logic [3:0] ci0_seen;
    logic [5:0] ci1_seen;
    logic mon_free;
    mtx_state_t mtx;
    logic [4:0] bit_cnt;
    logic [31:0] rx_sh;
    logic [31:0] tx_sh;
    logic [31:0] tx_use;
    logic du_oe;

    logic next_pready;
    logic next_pslverr;
    logic [31:0] next_prdata;
    logic next_irq;
    gci_cfg_t next_cfg;
    gci_evt_t next_status;
    gci_evt_t next_mask;
    logic next_bar;
    logic [3:0] next_ci0_tx;
    logic [5:0] next_ci1_tx;
    logic [7:0] next_mon_tx;
    logic [3:0] next_ci0_rx;
    logic [5:0] next_ci1_rx;
    logic [7:0] next_mon_rx;
    logic [3:0] next_ci0_prev;
    logic [5:0] next_ci1_prev;
    logic [3:0] next_ci0_seen;
    logic [5:0] next_ci1_seen;
    logic next_mon_free;
    mtx_state_t next_mtx;
    logic [4:0] next_bit_cnt;
    logic [31:0] next_rx_sh;
    logic [31:0] next_tx_sh;
    logic [31:0] next_tx_use;
    logic next_du_oe;

    logic done;
    logic wr;
    logic rd;
    logic [31:0] frame;
    logic [31:0] rdv;
    logic hit;
    gci_evt_t set;
    gci_evt_t clr;
    logic [7:0] mon_in;
    logic ci0_drive;

    always_comb begin
        done = PSEL & PENABLE & pready;
        wr = done & PWRITE;
        rd = done & ~PWRITE;
        frame = {rx_sh[30:0], dd};
        mon_in = cfg.mon_sel ? frame[`POS_MON1 +: 8]
                             : frame[`POS_MON0 +: 8];
        ci0_drive = bar & cfg.tic_en;
        set = '0;
        clr = '0;
        rdv = 32'h0000_0000;
        hit = 1'b1;

        next_cfg = cfg;
        next_mask = mask;
        next_bar = bar;
        next_ci0_tx = ci0_tx;
        next_ci1_tx = ci1_tx;
        next_mon_tx = mon_tx;
        next_ci0_rx = ci0_rx;
        next_ci1_rx = ci1_rx;
        next_mon_rx = mon_rx;
        next_ci0_prev = ci0_prev;
        next_ci1_prev = ci1_prev;
        next_ci0_seen = ci0_seen;
        next_ci1_seen = ci1_seen;
        next_mon_free = mon_free;
        next_mtx = mtx;
        next_bit_cnt = bit_cnt;
        next_rx_sh = rx_sh;
        next_tx_sh = tx_sh;
        next_tx_use = tx_use;
        next_du_oe = du_oe;

        // Read decode; peeks carry no side effect
        case (PADDR[11:2])
            `IDX_STATUS: rdv[7:0] = {status.chg_ci1, status.chg_ci0,
                                     4'h0, status.mxba, status.mrda};
            `IDX_CONFIG: rdv[1:0] = {cfg.mon_en, cfg.mon_sel};
            `IDX_MASK: rdv[7:0] = {mask.chg_ci1, mask.chg_ci0,
                                   4'h0, mask.mxba, mask.mrda};
            `IDX_TIC: rdv[`BIT_TIC_EN] = cfg.tic_en;
            `IDX_CI0_TX: rdv[7:0] = {bar, 3'h0, ci0_tx};
            `IDX_CI0_RX: rdv[3:0] = ci0_rx;
            `IDX_CI0_PEEK: rdv[3:0] = ci0_rx;
            `IDX_CI1_TX: rdv[5:0] = ci1_tx;
            `IDX_CI1_RX: rdv[5:0] = ci1_rx;
            `IDX_CI1_PEEK: rdv[5:0] = ci1_rx;
            `IDX_MON_TX: rdv[7:0] = mon_tx;
            `IDX_MON_RX: rdv[7:0] = mon_rx;
            `IDX_MON_PEEK: rdv[7:0] = mon_rx;
            default: hit = 1'b0;
        endcase
        hit = hit & (PADDR[1:0] == 2'b00);
        // Refused reads return zero
        if (!hit) begin
            rdv = 32'h0000_0000;
        end

        next_pready = PSEL & PENABLE & ~pready;
        next_prdata = next_pready ? rdv : prdata;
        next_pslverr = next_pready & ~hit;

        // Writes; reserved bits are dropped, software keeps them at reset
        if (wr && hit) begin
            if (at(PADDR, `IDX_STATUS)) begin
                clr.chg_ci1 = PWDATA[`BIT_CHG_CI1];
                clr.chg_ci0 = PWDATA[`BIT_CHG_CI0];
                clr.mxba = PWDATA[`BIT_MXBA];
                clr.mrda = PWDATA[`BIT_MRDA];
            end
            if (at(PADDR, `IDX_CONFIG)) begin
                next_cfg.mon_sel = PWDATA[`BIT_MON_SEL];
                next_cfg.mon_en = PWDATA[`BIT_MON_EN];
            end
            if (at(PADDR, `IDX_MASK)) begin
                next_mask = {PWDATA[`BIT_CHG_CI1], PWDATA[`BIT_CHG_CI0],
                             PWDATA[`BIT_MXBA], PWDATA[`BIT_MRDA]};
            end
            if (at(PADDR, `IDX_TIC)) begin
                next_cfg.tic_en = PWDATA[`BIT_TIC_EN];
            end
            if (at(PADDR, `IDX_CI0_TX)) begin
                next_bar = PWDATA[`BIT_BAR];
                next_ci0_tx = PWDATA[3:0];
            end
            if (at(PADDR, `IDX_CI1_TX)) begin
                next_ci1_tx = PWDATA[5:0];
            end
            if (at(PADDR, `IDX_MON_TX) && mtx != MTX_SENDING) begin
                next_mon_tx = PWDATA[7:0];
                next_mtx = MTX_LOADED;
            end
        end
        if (rd && at(PADDR, `IDX_CI0_RX)) begin
            next_ci0_seen = ci0_rx;
        end
        if (rd && at(PADDR, `IDX_CI1_RX)) begin
            next_ci1_seen = ci1_rx;
        end
        if (rd && at(PADDR, `IDX_MON_RX)) begin
            next_mon_free = 1'b1;
        end

        // Link: rising edge advances the slot, falling edge samples
        if (dcl_rise) begin
            if (fsc) begin
                next_bit_cnt = 5'h00;
                // Slots not in use stay released
                next_tx_sh = 32'hffff_ffff;
                next_tx_use = 32'h0000_0000;
                next_tx_sh[`POS_CI1 +: 6] = ci1_tx;
                next_tx_use[`POS_CI1 +: 6] = 6'h3f;
                if (ci0_drive) begin
                    next_tx_sh[`POS_CI0 +: 4] = ci0_tx;
                    next_tx_use[`POS_CI0 +: 4] = 4'hf;
                end
                if (mtx == MTX_LOADED && cfg.mon_en) begin
                    next_mtx = MTX_SENDING;
                    if (cfg.mon_sel) begin
                        next_tx_sh[`POS_MON1 +: 8] = mon_tx;
                        next_tx_use[`POS_MON1 +: 8] = 8'hff;
                    end else begin
                        next_tx_sh[`POS_MON0 +: 8] = mon_tx;
                        next_tx_use[`POS_MON0 +: 8] = 8'hff;
                    end
                end
            end else begin
                next_bit_cnt = bit_cnt + 5'h01;
                next_tx_sh = {tx_sh[30:0], 1'b1};
                next_tx_use = {tx_use[30:0], 1'b0};
            end
            // Open drain: only a used slot carrying zero pulls the line
            next_du_oe = next_tx_use[31] & ~next_tx_sh[31];
        end
        if (dcl_fall) begin
            next_rx_sh = frame;
            if (bit_cnt == `FRAME_LAST) begin
                // Two equal frames in a row make data valid
                next_ci0_prev = frame[`POS_CI0 +: 4];
                if (frame[`POS_CI0 +: 4] == ci0_prev) begin
                    next_ci0_rx = ci0_prev;
                end
                next_ci1_prev = frame[`POS_CI1 +: 6];
                if (frame[`POS_CI1 +: 6] == ci1_prev) begin
                    next_ci1_rx = ci1_prev;
                end
                // Idle monitor slot reads as all ones and is skipped
                if (cfg.mon_en && next_mon_free && mon_in != 8'hff) begin
                    next_mon_rx = mon_in;
                    next_mon_free = 1'b0;
                    set.mrda = 1'b1;
                end
                if (mtx == MTX_SENDING) begin
                    next_mtx = MTX_IDLE;
                    set.mxba = 1'b1;
                end
            end
        end
        if (!cfg.mon_en) begin
            next_mon_rx = `RST_MON_RX;
            next_mon_free = 1'b1;
        end

        set.chg_ci0 = next_ci0_rx != ci0_rx && next_ci0_rx != next_ci0_seen;
        set.chg_ci1 = next_ci1_rx != ci1_rx && next_ci1_rx != next_ci1_seen;
        next_status = set | (status & ~clr);
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
            irq <= 1'b0;
            cfg <= '0;
            status <= '0;
            mask <= '0;
            bar <= 1'b0;
            ci0_tx <= `RST_CI0;
            ci1_tx <= `RST_CI1;
            mon_tx <= `RST_MON_TX;
            ci0_rx <= `RST_CI0;
            ci1_rx <= `RST_CI1;
            mon_rx <= `RST_MON_RX;
            ci0_prev <= `RST_CI0;
            ci1_prev <= `RST_CI1;
            ci0_seen <= `RST_CI0;
            ci1_seen <= `RST_CI1;
            mon_free <= 1'b1;
            mtx <= MTX_IDLE;
            bit_cnt <= 5'h00;
            rx_sh <= 32'hffff_ffff;
            tx_sh <= 32'hffff_ffff;
            tx_use <= 32'h0000_0000;
            du_oe <= 1'b0;
        end else if (CE) begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            irq <= next_irq;
            cfg <= next_cfg;
            status <= next_status;
            mask <= next_mask;
            bar <= next_bar;
            ci0_tx <= next_ci0_tx;
            ci1_tx <= next_ci1_tx;
            mon_tx <= next_mon_tx;
            ci0_rx <= next_ci0_rx;
            ci1_rx <= next_ci1_rx;
            mon_rx <= next_mon_rx;
            ci0_prev <= next_ci0_prev;
            ci1_prev <= next_ci1_prev;
            ci0_seen <= next_ci0_seen;
            ci1_seen <= next_ci1_seen;
            mon_free <= next_mon_free;
            mtx <= next_mtx;
            bit_cnt <= next_bit_cnt;
            rx_sh <= next_rx_sh;
            tx_sh <= next_tx_sh;
            tx_use <= next_tx_use;
            du_oe <= next_du_oe;
        end
    end

    assign PREADY = pready;
    assign PSLVERR = pslverr;
    assign PRDATA = prdata;
    assign IRQ = irq;
    assign UPSTREAM_DATA_LINE_OE = du_oe;
    assign UPSTREAM_DATA_LINE_OUT = 1'b0;

endmodule : gci_ci_monitor_regs

// ===== testbench/gci_ci_monitor_regs_assertions.sv
// Purpose: Port checks on the C/I and monitor register bank.
// Assumes: Clock enable held high.
// Notes: Link slot timing seen only through the output enable.
module gci_ci_monitor_regs_assertions #(
    parameter int ADDR_W = 12
) (
    input logic CLK_SYS,
    input logic RESETN,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [ADDR_W-1:0] PADDR,
    input logic [31:0] PRDATA,
    input logic PREADY,
    input logic PSLVERR,
    input logic IRQ,
    input logic LINK_CLK_IN,
    input logic UPSTREAM_DATA_LINE_OUT,
    input logic UPSTREAM_DATA_LINE_OE
);
    logic wr_done;

    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RESETN);

    always_ff @(posedge CLK_SYS or negedge RESETN) begin
        if (!RESETN) begin
            wr_done <= 1'b0;
        end else begin
            wr_done <= PSEL && PENABLE && PREADY && PWRITE;
        end
    end

    AST_SETUP_NO_READY: assert property (PSEL && !PENABLE |-> !PREADY)
        else $error("ready in setup cycle");
    AST_ACCESS_WAIT: assert property ($rose(PENABLE) && PSEL |->
        !PREADY ##1 PREADY) else $error("ready not in second access cycle");
    AST_READY_PULSE: assert property (PREADY |=> !PREADY)
        else $error("ready longer than one cycle");
    AST_ERR_WITH_READY: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    AST_MISALIGNED: assert property (PREADY && PADDR[1:0] != 2'b00 |-> PSLVERR)
        else $error("misaligned access accepted");
    AST_ERR_DATA: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0)
        else $error("refused read returned data");
    AST_HIGH_ZERO: assert property (PREADY && !PWRITE |-> PRDATA[31:8] == 24'h0)
        else $error("upper read bits not zero");
    AST_IRQ_FALL: assert property ($fell(IRQ) |-> wr_done || $past(wr_done))
        else $error("interrupt dropped without a write");
    AST_LINE_LEVEL: assert property (UPSTREAM_DATA_LINE_OUT == 1'b0)
        else $error("data line driven high");
    AST_OE_SLOT: assert property ($changed(UPSTREAM_DATA_LINE_OE) |->
        $past(LINK_CLK_IN, 3)) else $error("enable moved off slot start");

    cover property ($rose(IRQ));
    cover property (PSLVERR);
    cover property ($rose(UPSTREAM_DATA_LINE_OE));
endmodule : gci_ci_monitor_regs_assertions

bind gci_ci_monitor_regs gci_ci_monitor_regs_assertions #(.ADDR_W(ADDR_W))
    u_gci_ci_monitor_regs_assertions (.CLK_SYS(CLK_SYS), .RESETN(RESETN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IRQ(IRQ),
    .LINK_CLK_IN(LINK_CLK_IN), .UPSTREAM_DATA_LINE_OUT(UPSTREAM_DATA_LINE_OUT),
    .UPSTREAM_DATA_LINE_OE(UPSTREAM_DATA_LINE_OE));

// ===== testbench/gci_peer_model.sv
// Purpose: Far-end link device sending and capturing 32-slot frames.
// Assumes: 64 ns bit clock, stopped while run is low.
// Notes: Data set mid-high, sync set mid-low, so both are far from edges.
module gci_peer_model (
    input logic run,
    input logic [31:0] tx_frame,
    input logic du_wire,
    output logic dcl,
    output logic fsc,
    output logic dd,
    output logic [31:0] rx_frame,
    output int frame_cnt
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [31:0] cur;
    logic [31:0] cap;

    initial begin
        dcl = 1'b0;
        fsc = 1'b1;
        dd = 1'b1;
        rx_frame = '1;
        cap = '1;
        frame_cnt = 0;
        forever begin
            if (!run) begin
                #16 dd = ~dd;
            end else begin
                for (int k = 0; k < 32; k++) begin
                    if (k == 0) begin
                        cur = tx_frame;
                    end
                    dcl = 1'b1;
                    #16 dd = cur[31-k];
                    #16 dcl = 1'b0;
                    cap[31-k] = du_wire;
                    #8;
                    if (k == 31) begin
                        rx_frame = cap;
                        frame_cnt++;
                    end
                    #8 fsc = (k == 31);
                    #16;
                end
            end
        end
    end
endmodule : gci_peer_model

// ===== testbench/gci_ci_monitor_regs_test.sv
// Purpose: Register and link scenarios for the C/I and monitor bank.
// Assumes: Clock enable tied high; peer model drives the link.
// Notes: Register data written with reserved bits zero.
`include "gci_ci_monitor_map.svh"
module gci_ci_monitor_regs_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk_sys = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rd, tx_frame = '1, rx_frame;
    logic pready, pslverr, irq, oe, du_out, dcl, fsc, dd, err, run = 0;
    logic du_wire;
    int frame_cnt, fails = 0, comparisons = 0;
    logic [9:0] ridx [11] = '{`IDX_CI0_TX, `IDX_CI0_RX, `IDX_CI0_PEEK,
        `IDX_CI1_TX, `IDX_CI1_RX, `IDX_CI1_PEEK, `IDX_MON_TX, `IDX_MON_RX,
        `IDX_MON_PEEK, `IDX_STATUS, `IDX_MASK};
    logic [7:0] rrst [11] = '{8'h0f, 8'h0f, 8'h0f, 8'h3f, 8'h3f, 8'h3f,
        8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    always #2.5 clk_sys = ~clk_sys;
    assign du_wire = oe ? du_out : 1'b1;

    gci_ci_monitor_regs #(.ADDR_W(12)) u_gci_ci_monitor_regs (
        .CLK_SYS(clk_sys), .RESETN(resetn), .CE(1'b1), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq),
        .LINK_CLK_IN(dcl), .FRAME_SYNC_IN(fsc), .DOWNSTREAM_DATA_LINE_IN(dd),
        .UPSTREAM_DATA_LINE_OUT(du_out), .UPSTREAM_DATA_LINE_OE(oe));
    gci_peer_model u_gci_peer_model (.run(run), .tx_frame(tx_frame),
        .du_wire(du_wire), .dcl(dcl), .fsc(fsc), .dd(dd),
        .rx_frame(rx_frame), .frame_cnt(frame_cnt));

    task automatic wrap_up();
        if (fails == 0 && comparisons > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic fchk(input string nm, input logic [7:0] e,
                        input logic [7:0] g);
        chk(nm, {24'h00_0000, e}, {24'h00_0000, g});
    endtask : fchk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        // Only the watchdog ends a wait
        while (pready !== 1'b1) begin
            @(posedge clk_sys);
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [9:0] i, input logic [7:0] d);
        apb(1'b1, {i, 2'b00}, {24'h00_0000, d});
    endtask : wr

    task automatic rdc(input logic [9:0] i, input logic [7:0] e);
        apb(1'b0, {i, 2'b00}, 32'h0000_0000);
        chk($sformatf("register %h", i), {24'h00_0000, e}, rd);
    endtask : rdc

    task automatic frames(input int n);
        repeat (n) @(frame_cnt);
        repeat (8) @(posedge clk_sys);
    endtask : frames

    function automatic logic [31:0] frm(input logic [7:0] m0, m1,
                                        input logic [3:0] c0,
                                        input logic [5:0] c1);
        return {m0, m1, c0, c1, 6'h3f};
    endfunction : frm

    initial begin
        #200000;
        fails++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge clk_sys);
        resetn <= 1'b1;
        for (int k = 0; k < 11; k++) rdc(ridx[k], rrst[k]);
        apb(1'b0, {10'h2c0, 2'b00}, 32'h0000_0000);
        chk("unmapped data", 32'h0000_0000, rd);
        fchk("unmapped error", 8'h01, {7'h00, err});
        apb(1'b0, {`IDX_CI1_TX, 2'b10}, 32'h0000_0000);
        fchk("misaligned error", 8'h01, {7'h00, err});
        chk("misaligned data", 32'h0000_0000, rd);
        apb(1'b1, {`IDX_CI1_TX, 2'b10}, 32'h0000_0015);
        fchk("misaligned write error", 8'h01, {7'h00, err});
        rdc(`IDX_CI1_TX, 8'h3f);
        run = 1'b1;
        wr(`IDX_MASK, 8'hc3);
        wr(`IDX_CONFIG, 8'h02);
        tx_frame = frm(8'hff, 8'hff, 4'h5, 6'h2a);
        frames(2);
        rdc(`IDX_CI0_PEEK, 8'h0f);
        rdc(`IDX_CI1_PEEK, 8'h3f);
        frames(1);
        rdc(`IDX_CI0_PEEK, 8'h05);
        rdc(`IDX_CI1_PEEK, 8'h2a);
        rdc(`IDX_STATUS, 8'hc0);
        fchk("irq raised", 8'h01, {7'h00, irq});
        rdc(`IDX_CI0_RX, 8'h05);
        rdc(`IDX_CI1_RX, 8'h2a);
        wr(`IDX_STATUS, 8'hc0);
        frames(2);
        rdc(`IDX_STATUS, 8'h00);
        wr(`IDX_MASK, 8'h80);
        tx_frame = frm(8'hff, 8'hff, 4'h6, 6'h2a);
        frames(3);
        rdc(`IDX_STATUS, 8'h40);
        fchk("irq masked", 8'h00, {7'h00, irq});
        wr(`IDX_MASK, 8'hc3);
        repeat (2) @(posedge clk_sys);
        fchk("irq unmasked", 8'h01, {7'h00, irq});
        wr(`IDX_STATUS, 8'hc3);
        tx_frame = frm(8'h5a, 8'hff, 4'h6, 6'h2a);
        frames(2);
        rdc(`IDX_MON_PEEK, 8'h5a);
        rdc(`IDX_STATUS, 8'h01);
        tx_frame = frm(8'h3c, 8'hff, 4'h6, 6'h2a);
        frames(2);
        rdc(`IDX_MON_PEEK, 8'h5a);
        rdc(`IDX_MON_RX, 8'h5a);
        frames(2);
        rdc(`IDX_MON_PEEK, 8'h3c);
        wr(`IDX_CONFIG, 8'h03);
        tx_frame = frm(8'hff, 8'hc3, 4'h6, 6'h2a);
        rdc(`IDX_MON_RX, 8'h3c);
        frames(2);
        rdc(`IDX_MON_PEEK, 8'hc3);
        wr(`IDX_CONFIG, 8'h01);
        rdc(`IDX_MON_RX, 8'h00);
        wr(`IDX_CI1_TX, 8'h15);
        wr(`IDX_CI0_TX, 8'h89);
        frames(2);
        fchk("ci0 slot", 8'h0f, {4'h0, rx_frame[15:12]});
        fchk("ci1 slot", 8'h15, {2'h0, rx_frame[11:6]});
        fchk("unused slots", 8'h3f, {2'h0, rx_frame[5:0]});
        wr(`IDX_TIC, 8'h80);
        frames(2);
        fchk("ci0 slot", 8'h09, {4'h0, rx_frame[15:12]});
        frames(1);
        fchk("ci0 repeat", 8'h09, {4'h0, rx_frame[15:12]});
        fchk("ci1 repeat", 8'h15, {2'h0, rx_frame[11:6]});
        wr(`IDX_CONFIG, 8'h02);
        wr(`IDX_STATUS, 8'hc3);
        wr(`IDX_MON_TX, 8'ha5);
        frames(2);
        fchk("monitor sent", 8'ha5, rx_frame[31:24]);
        rdc(`IDX_STATUS, 8'h02);
        frames(1);
        fchk("monitor idle", 8'hff, rx_frame[31:24]);
        fchk("monitor1 idle", 8'hff, rx_frame[23:16]);
        wrap_up();
    end
endmodule : gci_ci_monitor_regs_test
